// *** include/status_reg_pkg.sv ***
// Purpose: Shared constants for the serial NAND status and drive-strength feature registers.
// Assumes: One system clock; serial link pins are sampled, not used as a clock.
// Notes: Opcodes, feature addresses, status bit positions and reset values live here.
package status_reg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial opcodes understood by this block.
  localparam logic [7:0] OPC_WR_ENABLE = 8'h06;  // Arms the write latch.
  localparam logic [7:0] OPC_WR_DISABLE = 8'h04;  // Disarms the write latch.
  localparam logic [7:0] OPC_FEAT_GET = 8'h0F;  // Feature read.
  localparam logic [7:0] OPC_FEAT_SET = 8'h1F;  // Feature write.
  localparam logic [7:0] OPC_PAGE_READ = 8'h13;  // Array page read into cache.
  localparam logic [7:0] OPC_COMMIT = 8'h10;  // Cache to array commit.
  localparam logic [7:0] OPC_ERASE = 8'hD8;  // Block erase.
  localparam logic [7:0] OPC_RESET = 8'hFF;  // Stops operations and clears the ECC field and failure flags.

  ////////////////////////////////////////////////////////////////////////////////
  // Feature addresses (register offsets on the serial link).
  localparam logic [7:0] FA_OPERATION_STATUS = 8'hC0;  // Read-only status.
  localparam logic [7:0] FA_OUTPUT_DRIVE = 8'hD0;  // Read/write drive setting.

  ////////////////////////////////////////////////////////////////////////////////
  // Status byte layout.
  localparam int BIT_BUSY = 0;  // Operation in progress.
  localparam int BIT_LATCH = 1;  // Write latch armed.
  localparam int BIT_EFAIL = 2;  // Erase failure.
  localparam int BIT_PFAIL = 3;  // Program failure.
  localparam int ECC_LSB = 4;  // ECC result field occupies 7:4.

  // ECC result encodings.
  localparam logic [3:0] ECC_CLEAN = 4'h0;  // No bit errors.
  localparam logic [3:0] ECC_MAX_FIX = 4'h8;  // Largest corrected count.
  localparam logic [3:0] ECC_UNFIXED = 4'hF;  // Beyond correction capability.

  // Reset value and frame limits.
  localparam logic [7:0] DRIVE_RESET = 8'h00;  // Plain default for drive setting.
  localparam logic [2:0] BIT_LAST = 3'h7;  // Last bit index of a byte.
  localparam logic [1:0] ADDR_BYTES = 2'h3;  // Row address bytes per array command.

  // Array operation kinds handed to the sequencer.
  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_ERASE,
    OP_RESET
  } array_op_t;

endpackage : status_reg_pkg

// *** logic/nand_status_register.sv ***
// Purpose: Serial feature-register front end holding the NAND status and drive-strength registers.
// Assumes: Mode 0 serial link, clock far slower than clk_sys; array sequencer on clk_sys.
// Notes: Link pins pass two flops; edges of the serial clock are found by sampling.

////////////////////////////////////////////////////////////////////////////////
module nand_status_register
  import status_reg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  output logic array_start,
  output array_op_t array_op,
  output logic [23:0] target_row,
  input wire logic target_locked,
  input wire logic array_done,
  input wire logic array_fail,
  input wire logic [3:0] ecc_err_count,
  input wire logic ecc_uncorrectable,
  output logic [7:0] drive_strength
);

  ////////////////////////////////////////////////////////////////////////////////
  // Link synchronisers; only the second stage and later are read by logic.
  logic [1:0] sck_sy_r;  // Serial clock synchroniser.
  logic [1:0] cs_sy_r;  // Select synchroniser.
  logic [1:0] si_sy_r;  // Data-in synchroniser.
  logic sck_d_r;  // Delayed synced clock for edge finding.
  logic cs_d_r;  // Delayed synced select.

  // Sync flops only register the pins.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_sy_r <= 2'h0;
      cs_sy_r <= 2'h3;
      si_sy_r <= 2'h0;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_sy_r <= {sck_sy_r[0], sck};
      cs_sy_r <= {cs_sy_r[0], cs_n};
      si_sy_r <= {si_sy_r[0], si};
      sck_d_r <= sck_sy_r[1];
      cs_d_r <= cs_sy_r[1];
    end
  end

  logic sck_rise;  // Data is sampled here.
  logic sck_fall;  // Data is launched here.
  logic cs_high;  // Link idle.
  logic cs_rise;  // End of a command frame.
  assign sck_rise = sck_sy_r[1] & ~sck_d_r;
  assign sck_fall = ~sck_sy_r[1] & sck_d_r;
  assign cs_high = cs_sy_r[1];
  assign cs_rise = cs_sy_r[1] & ~cs_d_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Maps a raw corrector result onto the reported field.
  function automatic logic [3:0] ecc_code(input logic [3:0] cnt, input logic unfix);
    if (unfix || cnt > ECC_MAX_FIX) begin
      ecc_code = ECC_UNFIXED;
    end else begin
      ecc_code = cnt;
    end
  endfunction : ecc_code

  ////////////////////////////////////////////////////////////////////////////////
  // Frame decoder states.
  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_FADDR,
    ST_RD,
    ST_WR,
    ST_SKIP
  } frame_t;

  frame_t st_r, st_nxt;  // Frame position.
  logic [2:0] bit_r, bit_nxt;  // Bit within byte.
  logic [7:0] rx_r, rx_nxt;  // Incoming shift register.
  logic [7:0] cmd_r, cmd_nxt;  // Opcode of the frame.
  logic [1:0] acnt_r, acnt_nxt;  // Row address bytes received.
  logic [7:0] fa_r, fa_nxt;  // Feature address of the frame.
  logic [23:0] row_r, row_nxt;  // Row address being collected.
  logic [7:0] tx_r, tx_nxt;  // Outgoing shift register.
  logic so_r, so_nxt;  // Data-out flop.
  logic oen_r, oen_nxt;  // Data-out enable, low drives.
  logic write_latch_armed_r, write_latch_armed_nxt;  // Write latch.
  logic busy_r, busy_nxt;  // Operation in progress.
  logic pfail_r, pfail_nxt;  // Program failure.
  logic efail_r, efail_nxt;  // Erase failure.
  logic [3:0] ecc_r, ecc_nxt;  // ECC result field.
  logic [7:0] drv_r, drv_nxt;  // Drive-strength register.
  logic start_r, start_nxt;  // Sequencer start pulse.
  array_op_t op_r, op_nxt;  // Operation in flight.
  logic boot_r, boot_nxt;  // Power-on page read pending.
  logic [7:0] byte_in;  // Byte completing on this edge.
  logic [7:0] status;  // Live status byte.

  assign byte_in = {rx_r[6:0], si_sy_r[1]};
  // Bit placement of the status byte.
  assign status = {ecc_r, pfail_r, efail_r, write_latch_armed_r, busy_r};

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole register and frame state.
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    rx_nxt = rx_r;
    cmd_nxt = cmd_r;
    acnt_nxt = acnt_r;
    fa_nxt = fa_r;
    row_nxt = row_r;
    tx_nxt = tx_r;
    so_nxt = so_r;
    oen_nxt = oen_r;
    write_latch_armed_nxt = write_latch_armed_r;
    busy_nxt = busy_r;
    pfail_nxt = pfail_r;
    efail_nxt = efail_r;
    ecc_nxt = ecc_r;
    drv_nxt = drv_r;
    start_nxt = 1'b0;
    op_nxt = op_r;
    boot_nxt = 1'b0;
    // Power-on read of block 0 page 0 fills the ECC field.
    if (boot_r) begin
      row_nxt = 24'h000000;
      busy_nxt = 1'b1;
      ecc_nxt = ECC_CLEAN;
      start_nxt = 1'b1;
      op_nxt = OP_READ;
    end
    if (cs_high) begin
      // Idle link: release data-out and rearm the decoder.
      st_nxt = ST_CMD;
      bit_nxt = 3'h0;
      oen_nxt = 1'b1;
      // Array commands run when the frame closes with a full row address.
      if (cs_rise && st_r == ST_ADDR && acnt_r == ADDR_BYTES && !busy_r) begin
        case (cmd_r)
          OPC_PAGE_READ: begin
            ecc_nxt = ECC_CLEAN;
            busy_nxt = 1'b1;
            start_nxt = 1'b1;
            op_nxt = OP_READ;
          end
          OPC_COMMIT: begin
            pfail_nxt = 1'b0;
            if (write_latch_armed_r) begin
              write_latch_armed_nxt = 1'b0;
              if (target_locked) begin
                pfail_nxt = 1'b1;
              end else begin
                busy_nxt = 1'b1;
                start_nxt = 1'b1;
                op_nxt = OP_PROGRAM;
              end
            end
          end
          OPC_ERASE: begin
            efail_nxt = 1'b0;
            // Without an armed latch the erase is dropped.
            if (write_latch_armed_r) begin
              write_latch_armed_nxt = 1'b0;
              if (target_locked) begin
                efail_nxt = 1'b1;
              end else begin
                busy_nxt = 1'b1;
                start_nxt = 1'b1;
                op_nxt = OP_ERASE;
              end
            end
          end
          default: ;
        endcase
      end
    end else if (sck_rise) begin
      // Sample one bit; act when a byte completes.
      rx_nxt = byte_in;
      bit_nxt = bit_r + 3'h1;
      if (bit_r == BIT_LAST) begin
        case (st_r)
          ST_CMD: begin
            cmd_nxt = byte_in;
            acnt_nxt = 2'h0;
            st_nxt = ST_SKIP;
            case (byte_in)
              OPC_WR_ENABLE: write_latch_armed_nxt = 1'b1;
              OPC_WR_DISABLE: write_latch_armed_nxt = 1'b0;
              OPC_FEAT_GET, OPC_FEAT_SET: st_nxt = ST_FADDR;
              OPC_PAGE_READ, OPC_COMMIT, OPC_ERASE: st_nxt = ST_ADDR;
              OPC_RESET: begin
                // Reset clears results and runs as a busy operation.
                ecc_nxt = ECC_CLEAN;
                pfail_nxt = 1'b0;
                efail_nxt = 1'b0;
                busy_nxt = 1'b1;
                start_nxt = 1'b1;
                op_nxt = OP_RESET;
              end
              default: ;
            endcase
          end
          ST_ADDR: begin
            row_nxt = {row_r[15:0], byte_in};
            if (acnt_r != ADDR_BYTES) begin
              acnt_nxt = acnt_r + 2'h1;
            end
          end
          ST_FADDR: begin
            fa_nxt = byte_in;
            st_nxt = (cmd_r == OPC_FEAT_GET) ? ST_RD : ST_WR;
          end
          ST_WR: begin
            // Only the drive register is writable; status ignores writes.
            if (fa_r == FA_OUTPUT_DRIVE) begin
              drv_nxt = byte_in;
            end
            st_nxt = ST_SKIP;
          end
          default: ;
        endcase
      end
    end else if (sck_fall && st_r == ST_RD) begin
      // Each new byte reloads live state, so polling sees fresh status.
      oen_nxt = 1'b0;
      if (bit_r == 3'h0) begin
        case (fa_r)
          FA_OPERATION_STATUS: tx_nxt = status;
          FA_OUTPUT_DRIVE: tx_nxt = drv_r;
          default: tx_nxt = 8'h00;
        endcase
      end else begin
        tx_nxt = tx_r;
      end
      so_nxt = tx_nxt[7];
      tx_nxt = {tx_nxt[6:0], 1'b0};
    end
    // Completion comes last, so a result landing on the same edge as a reset command
    // wins over its clear, and a start on that edge keeps the busy flag up.
    if (busy_r && array_done) begin
      busy_nxt = start_nxt;
      case (op_r)
        OP_READ: ecc_nxt = ecc_code(ecc_err_count, ecc_uncorrectable);
        OP_PROGRAM: if (array_fail) pfail_nxt = 1'b1;
        OP_ERASE: if (array_fail) efail_nxt = 1'b1;
        default: ;
      endcase
    end
  end

  // Registers for the state above; boot flag catches the first cycle after reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= ST_CMD;
      bit_r <= 3'h0;
      rx_r <= 8'h00;
      cmd_r <= 8'h00;
      acnt_r <= 2'h0;
      fa_r <= 8'h00;
      row_r <= 24'h000000;
      tx_r <= 8'h00;
      so_r <= 1'b0;
      oen_r <= 1'b1;
      write_latch_armed_r <= 1'b0;
      busy_r <= 1'b0;
      pfail_r <= 1'b0;
      efail_r <= 1'b0;
      ecc_r <= ECC_CLEAN;
      drv_r <= DRIVE_RESET;
      start_r <= 1'b0;
      op_r <= OP_READ;
      boot_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      rx_r <= rx_nxt;
      cmd_r <= cmd_nxt;
      acnt_r <= acnt_nxt;
      fa_r <= fa_nxt;
      row_r <= row_nxt;
      tx_r <= tx_nxt;
      so_r <= so_nxt;
      oen_r <= oen_nxt;
      write_latch_armed_r <= write_latch_armed_nxt;
      busy_r <= busy_nxt;
      pfail_r <= pfail_nxt;
      efail_r <= efail_nxt;
      ecc_r <= ecc_nxt;
      drv_r <= drv_nxt;
      start_r <= start_nxt;
      op_r <= op_nxt;
      boot_r <= boot_nxt;
    end
  end

  assign so = so_r;
  assign so_oe_n = oen_r;
  assign array_start = start_r;
  assign array_op = op_r;
  assign target_row = row_r;
  assign drive_strength = drv_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic exec_now;  // Frame close with a full address while idle.
  assign exec_now = cs_rise && st_r == ST_ADDR && acnt_r == ADDR_BYTES && !busy_r;

  a_latch_arms: assert property (!cs_high && sck_rise && bit_r == BIT_LAST && st_r == ST_CMD
    && byte_in == OPC_WR_ENABLE |=> write_latch_armed_r) else $error("write latch not armed");
  a_latch_disarms: assert property (!cs_high && sck_rise && bit_r == BIT_LAST && st_r == ST_CMD
    && byte_in == OPC_WR_DISABLE |=> !write_latch_armed_r) else $error("write latch not disarmed");
  a_ecc_range: assert property (ecc_r <= ECC_MAX_FIX || ecc_r == ECC_UNFIXED)
    else $error("ECC field holds an illegal code");
  a_ecc_read_clear: assert property (exec_now && cmd_r == OPC_PAGE_READ
    |=> ecc_r == ECC_CLEAN && busy_r ##1 array_op == OP_READ) else $error("read start wrong");
  a_erase_unarmed: assert property (exec_now && cmd_r == OPC_ERASE && !write_latch_armed_r
    |=> !busy_r && !start_r) else $error("erase ran without latch");
  a_erase_locked: assert property (exec_now && cmd_r == OPC_ERASE && write_latch_armed_r && target_locked
    |=> status == 8'h04) else $error("locked erase status not 04h");
  a_prog_locked: assert property (exec_now && cmd_r == OPC_COMMIT && write_latch_armed_r && target_locked
    |=> status == 8'h08 ##1 !busy_r) else $error("locked program status not 08h");
  a_busy_start: assert property ($rose(busy_r) |-> start_nxt == 1'b0 && $past(start_nxt))
    else $error("busy rose without a start");
  a_busy_ends: assert property (busy_r && array_done |=> busy_r == $past(start_nxt))
    else $error("busy held after completion");
  a_pfail_sets: assert property (busy_r && array_done && op_r == OP_PROGRAM && array_fail
    |=> pfail_r[*2]) else $error("program failure lost");
  a_status_layout: assert property (!cs_high && sck_fall && st_r == ST_RD && bit_r == 3'h0
    && fa_r == FA_OPERATION_STATUS |=> !so_oe_n && so == $past(ecc_r[3])) else $error("status byte not ECC first");

  c_read_status: cover property (!oen_r && fa_r == FA_OPERATION_STATUS);
  c_drive_write: cover property (drv_r != DRIVE_RESET);
  c_erase_fail: cover property ($rose(efail_r));
  c_prog_done: cover property (busy_r && array_done && op_r == OP_PROGRAM);

endmodule : nand_status_register

// *** verif/spi_host_model.sv ***
// Purpose: Host controller model that shifts whole byte frames over the serial link.
// Assumes: Mode 0 link, 160 ns clock period, clock idle low and still between frames.
// Notes: Frame task is called by the bench; bytes are left aligned, most significant first.
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle levels at time zero: deselected, clock low.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // Data is launched on the low phase and the device output is taken at each rise.
  // An undriven output reads as unknown, so a missing enable can never match.
  task automatic frame(input logic [39:0] tx, input int nbytes, output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < nbytes * 8; i++) begin
      si = tx[39 - i];
      #80 sck = 1'b1;
      rx = {rx[6:0], (so_oe_n === 1'b0) ? so : 1'bx};
      #80 sck = 1'b0;
    end
    cs_n = 1'b1;
    // After release the data line shows the inverse, never a stale bit.
    si = ~si;
    #80;
  endtask : frame
endmodule : spi_host_model

// *** verif/nand_status_register_tb.sv ***
// Purpose: Self-checking bench for the status and drive-strength feature registers.
// Assumes: The host model drives the link; this module plays the array sequencer.
// Notes: Random rows and drive values come from a fixed seed; error counts come from a fixed table.
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module nand_status_register_tb;
  import status_reg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, rst, sck, cs_n, si, so, so_oe_n, array_start;
  logic target_locked, array_done, array_fail, ecc_uncorrectable;
  logic [3:0] ecc_err_count;
  logic [23:0] target_row, row, last_row;
  logic [7:0] drive_strength, v, d;
  array_op_t array_op, last_op;
  int n_errors = 0, compares = 0, n_starts = 0, cycles = 0;
  integer seed = 32'he6c381f6;
  logic [3:0] ecc_e; // Expected ECC field after the latest read.
  int cnt_tab [6] = '{1, 8, 9, 8, 5, 0}; // Last case is clean so later codes are whole bytes.
  logic unc_tab [6] = '{0, 0, 0, 1, 0, 0};

  nand_status_register u_dut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n), .array_start(array_start), .array_op(array_op), .target_row(target_row),
    .target_locked(target_locked), .array_done(array_done), .array_fail(array_fail),
    .ecc_err_count(ecc_err_count), .ecc_uncorrectable(ecc_uncorrectable), .drive_strength(drive_strength));
  spi_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, a record of array starts, and a cycle ceiling against hangs.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (rst === 1'b0 && array_start === 1'b1) begin
      n_starts++;
      last_op = array_op;
      last_row = target_row;
    end
    if (cycles == 80000) begin
      n_errors++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Expected ECC code: counts past eight cannot have been corrected.
  function automatic logic [3:0] ecc_code(input int cnt, input logic unc);
    return (unc || cnt > 8) ? ECC_UNFIXED : 4'(cnt);
  endfunction : ecc_code

  task automatic rd(input logic [7:0] fa, output logic [7:0] r);
    u_host.frame({OPC_FEAT_GET, fa, 24'h000000}, 3, r);
  endtask : rd
  task automatic cmd(input logic [7:0] op);
    u_host.frame({op, 32'h00000000}, 1, v);
  endtask : cmd
  task automatic arr(input logic [7:0] op, input logic [23:0] r);
    u_host.frame({op, r, 8'h00}, 4, v);
  endtask : arr
  // Sequencer answer: one-cycle done pulse carrying the outcome.
  task automatic finish(input logic f, input int cnt, input logic unc);
    @(negedge clk_sys);
    array_done = 1'b1;
    array_fail = f;
    ecc_err_count = (cnt > 15) ? 4'hF : 4'(cnt);
    ecc_uncorrectable = unc;
    @(negedge clk_sys);
    array_done = 1'b0;
  endtask : finish
  // The host reads status until the busy flag drops, giving up after eight reads.
  task automatic poll(output logic [7:0] r);
    for (int i = 0; i < 8; i++) begin
      rd(FA_OPERATION_STATUS, r);
      if (r[BIT_BUSY] === 1'b0) break;
    end
  endtask : poll
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst = 1'b1;
    {target_locked, array_done, array_fail, ecc_uncorrectable} = 4'h0;
    ecc_err_count = 4'h0;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    repeat (8) @(negedge clk_sys);
    // Power-on read of the first page; busy until the sequencer answers.
    `CHK("power_on_start", 1, n_starts)
    `CHK("power_on_op", OP_READ, last_op)
    `CHK("power_on_row", 24'h000000, last_row)
    rd(FA_OPERATION_STATUS, v);
    `CHK("status_busy", 8'h01, v)
    finish(1'b0, 3, 1'b0);
    poll(v);
    `CHK("status_power_ecc", 8'h30, v)
    // Page reads: field cleared while running, then the outcome code.
    for (int i = 0; i < 6; i++) begin
      row = 24'($random(seed));
      arr(OPC_PAGE_READ, row);
      `CHK("read_row", row, last_row)
      rd(FA_OPERATION_STATUS, v);
      `CHK("status_read_busy", 8'h01, v)
      finish(1'b0, cnt_tab[i], unc_tab[i]);
      poll(v);
      ecc_e = ecc_code(cnt_tab[i], unc_tab[i]);
      `CHK("status_ecc", {ecc_e, 4'h0}, v)
    end
    // Write latch armed and disarmed.
    cmd(OPC_WR_ENABLE);
    rd(FA_OPERATION_STATUS, v);
    `CHK("latch_set", 8'h02, v)
    cmd(OPC_WR_DISABLE);
    rd(FA_OPERATION_STATUS, v);
    `CHK("latch_clear", 8'h00, v)
    // Erase with a disarmed latch must not start anything.
    arr(OPC_ERASE, 24'h000040);
    `CHK("erase_ignored", 7, n_starts)
    // Erase then commit, each failing once and then passing.
    for (int k = 0; k < 2; k++) begin
      for (int f = 1; f >= 0; f--) begin
        cmd(OPC_WR_ENABLE);
        row = 24'($random(seed));
        arr(k ? OPC_COMMIT : OPC_ERASE, row);
        `CHK("array_op", k ? OP_PROGRAM : OP_ERASE, last_op)
        rd(FA_OPERATION_STATUS, v);
        `CHK("status_running", 8'h01, v)
        finish(1'(f), 0, 1'b0);
        poll(v);
        `CHK("status_outcome", {4'h0, 1'(f & k), 1'(f & ~k), 2'h0}, v)
      end
    end
    // Locked targets: no start, fixed failure codes, reset clears flags.
    target_locked = 1'b1;
    cmd(OPC_WR_ENABLE);
    arr(OPC_ERASE, 24'h000000);
    rd(FA_OPERATION_STATUS, v);
    `CHK("locked_erase", 8'h04, v)
    cmd(OPC_RESET);
    `CHK("reset_op", OP_RESET, last_op)
    finish(1'b0, 0, 1'b0);
    poll(v);
    `CHK("reset_erase_flag", 8'h00, v)
    cmd(OPC_WR_ENABLE);
    arr(OPC_COMMIT, 24'h000000);
    rd(FA_OPERATION_STATUS, v);
    `CHK("locked_program", 8'h08, v)
    `CHK("locked_no_start", 12, n_starts)
    target_locked = 1'b0;
    cmd(OPC_RESET);
    rd(FA_OPERATION_STATUS, v);
    `CHK("reset_running", 8'h01, v)
    finish(1'b0, 0, 1'b0);
    poll(v);
    // Drive register written and read back; the status offset refuses writes.
    d = 8'($random(seed));
    u_host.frame({OPC_FEAT_SET, FA_OUTPUT_DRIVE, d, 16'h0000}, 3, v);
    `CHK("drive_port", d, drive_strength)
    rd(FA_OUTPUT_DRIVE, v);
    `CHK("drive_read", d, v)
    u_host.frame({OPC_FEAT_SET, FA_OPERATION_STATUS, 8'hFF, 16'h0000}, 3, v);
    rd(FA_OPERATION_STATUS, v);
    `CHK("status_read_only", 8'h00, v)
    `CHK("output_released", 1'b1, so_oe_n)
    print_verdict();
  end
endmodule : nand_status_register_tb
